// file: core/cgc_top.sv
// clock generator control: axi4-lite registers, source switch, status
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`include "cgc_consts.svh"
module cgc_top (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [3:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [3:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic             xtal_osc_in,
  input  wire logic             vco_clock,
  input  wire cgc_pkg::cgc_stat_t loop_stat_in,
  input  wire logic             oscillator_enable_in,
  input  wire logic             stop_mode_in,
  output cgc_pkg::cgc_ctl_t     loop_ctl_out,
  output logic                  crystal_clock_out,
  output logic                  base_clock_out,
  output logic                  clockgen_interrupt
);
  import cgc_pkg::*;

  // effective multiplier, zero behaves as one
  function automatic logic [3:0] eff_n(input logic [3:0] m);
    eff_n = (m == 4'h0) ? 4'h1 : m;
  endfunction : eff_n

  // register decode of a byte address
  function automatic logic [1:0] reg_sel(input logic [3:0] a);
    case (a)
      `CGC_OFS_CTRL: reg_sel = 2'h1;
      `CGC_OFS_PBW:  reg_sel = 2'h2;
      `CGC_OFS_PMUL: reg_sel = 2'h3;
      default:       reg_sel = 2'h0;
    endcase
  endfunction : reg_sel

  // async inputs: xtal, vco, locked, tracking
  logic [3:0] s1_q, s2_q, s3_q, flt_q, flt_prev_q;
  logic [3:0] flt_d;
  logic       xtal_rise, vco_rise, lock_tog;

  // three-stage synchroniser; a level counts when stages 2 and 3 agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q       <= 4'h0;
      s2_q       <= 4'h0;
      s3_q       <= 4'h0;
      flt_q      <= 4'h0;
      flt_prev_q <= 4'h0;
    end else begin
      s1_q       <= {xtal_osc_in, vco_clock, loop_stat_in};
      s2_q       <= s1_q;
      s3_q       <= s2_q;
      flt_q      <= flt_d;
      flt_prev_q <= flt_q;
    end
  end

  // keep old value while stages disagree
  assign flt_d = (s2_q & s3_q) | (flt_q & (s2_q | s3_q));
  assign xtal_rise = flt_q[3] & ~flt_prev_q[3];
  assign vco_rise  = flt_q[2] & ~flt_prev_q[2];
  assign lock_tog  = flt_q[1] ^ flt_prev_q[1];

  // register state
  logic       ie_q, flag_q, pon_q, bsel_q, auto_q, acq_man_q, loss_q;
  logic [3:0] mul_q, vrs_q;
  logic       settled, tracking;

  assign settled  = auto_q & flt_q[1];
  assign tracking = auto_q ? flt_q[0] : acq_man_q;

  // axi write channel: address and data taken in either order
  logic       aw_q, w_q, bvalid_q;
  logic [3:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic       wstb_q, do_wr;
  logic [1:0] wsel;

  assign s_axi_awready = ~aw_q & ~bvalid_q;
  assign s_axi_wready  = ~w_q & ~bvalid_q;
  assign do_wr         = aw_q & w_q & ~bvalid_q;
  assign wsel          = reg_sel(awaddr_q);

  // capture write halves, answer once both are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      bvalid_q <= 1'b0;
      awaddr_q <= 4'h0;
      wbyte_q  <= 8'h00;
      wstb_q   <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wbyte_q <= s_axi_wdata[7:0];
        wstb_q  <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        aw_q     <= 1'b0;
        w_q      <= 1'b0;
        bvalid_q <= 1'b1;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  logic [1:0] bresp_q;
  // unmapped addresses answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bresp_q <= 2'h0;
    end else if (do_wr) begin
      bresp_q <= (wsel == 2'h0) ? 2'h2 : 2'h0;
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // write enables per register, low byte lane only
  logic wr_ctrl, wr_pbw, wr_pmul;
  assign wr_ctrl = do_wr & wstb_q & (wsel == 2'h1);
  assign wr_pbw  = do_wr & wstb_q & (wsel == 2'h2);
  assign wr_pmul = do_wr & wstb_q & (wsel == 2'h3);

  // axi read channel, one outstanding read
  logic        rvalid_q, rd_ctrl;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q, rsel;

  assign s_axi_arready = ~rvalid_q;
  assign rsel          = reg_sel(s_axi_araddr);
  assign rd_ctrl       = s_axi_arvalid & ~rvalid_q & (rsel == 2'h1);

  // read data registered; reserved high bits are zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= 2'h0;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q  <= (rsel == 2'h0) ? 2'h2 : 2'h0;
      case (rsel)
        2'h1: rdata_q <= {24'h0, ie_q & auto_q, flag_q & auto_q,
                          pon_q, bsel_q, 4'hf};
        2'h2: rdata_q <= {24'h0, auto_q, settled, tracking,
                          loss_q & bsel_q, 4'h0};
        2'h3: rdata_q <= {24'h0, mul_q, vrs_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // bandwidth mode and saved manual tracking value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      auto_q    <= 1'b0;
      acq_man_q <= 1'b0;
    end else if (wr_pbw) begin
      auto_q <= wbyte_q[`CGC_B_AUTO];
      // the value written while in auto mode is dropped
      if (!auto_q) begin
        acq_man_q <= wbyte_q[`CGC_B_TRACK];
      end
    end
  end

  // interrupt enable, only writable in auto mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ie_q <= 1'b0;
    end else if (wr_ctrl && auto_q) begin
      ie_q <= wbyte_q[`CGC_B_IE];
    end
  end

  // lock flag; a toggle in the read cycle wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else if (auto_q && lock_tog) begin
      flag_q <= 1'b1;
    end else if (rd_ctrl) begin
      flag_q <= 1'b0;
    end
  end

  // loop power and source select interlocks use old values,
  // so select cannot be set by the write that powers the loop on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pon_q  <= 1'b1;
      bsel_q <= 1'b0;
    end else begin
      if (wr_ctrl && (wbyte_q[`CGC_B_PON] || !bsel_q)) begin
        pon_q <= wbyte_q[`CGC_B_PON];
      end
      if (stop_mode_in || vrs_q == 4'h0) begin
        bsel_q <= 1'b0;
      end else if (wr_ctrl) begin
        bsel_q <= wbyte_q[`CGC_B_BSEL] & pon_q;
      end
    end
  end

  // multiplier and range, frozen while loop is on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mul_q <= `CGC_RST_MUL;
      vrs_q <= `CGC_RST_VRS;
    end else if (wr_pmul && !pon_q) begin
      mul_q <= wbyte_q[7:4];
      vrs_q <= wbyte_q[3:0];
    end
  end

  // crystal loss check: n*4 vco edges with no crystal edge
  logic [5:0] loss_cnt_q;
  logic [5:0] loss_lim;
  logic       loss_run_q;
  assign loss_lim = {eff_n(mul_q), 2'h0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loss_q     <= 1'b0;
      loss_run_q <= 1'b0;
      loss_cnt_q <= 6'h00;
    end else if (!bsel_q) begin
      loss_q     <= 1'b0;
      loss_run_q <= 1'b0;
    end else if (wr_pbw && wbyte_q[`CGC_B_LOSS]) begin
      loss_q     <= 1'b1;
      loss_run_q <= 1'b1;
      loss_cnt_q <= 6'h00;
    end else if (loss_run_q) begin
      if (xtal_rise) begin
        loss_q     <= 1'b0;
        loss_run_q <= 1'b0;
      end else if (vco_rise) begin
        loss_cnt_q <= loss_cnt_q + 6'h01;
        if (loss_cnt_q + 6'h01 >= loss_lim) begin
          loss_run_q <= 1'b0;
        end
      end
    end
  end

  // base clock switchover sequencer
  cgc_sw_t    sw_q;
  logic       src_q, base_q;
  logic [1:0] xcnt_q, vcnt_q;
  logic       xdone, vdone;
  assign xdone = xcnt_q == `CGC_SW_EDGES;
  // a stopped vco cannot deliver edges, so skip waiting on it
  assign vdone = vcnt_q == `CGC_SW_EDGES || !loop_ctl_out.loop_run;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_q   <= SW_RUN;
      src_q  <= 1'b0;
      xcnt_q <= 2'h0;
      vcnt_q <= 2'h0;
    end else if (stop_mode_in) begin
      sw_q  <= SW_RUN;
      src_q <= 1'b0;
    end else begin
      case (sw_q)
        SW_RUN: begin
          xcnt_q <= 2'h0;
          vcnt_q <= 2'h0;
          if (bsel_q != src_q) begin
            sw_q <= SW_DRAIN;
          end
        end
        SW_DRAIN: begin
          if (xtal_rise && !xdone) begin
            xcnt_q <= xcnt_q + 2'h1;
          end
          if (vco_rise && !vdone) begin
            vcnt_q <= vcnt_q + 2'h1;
          end
          if (xdone && vdone) begin
            sw_q <= SW_SWAP;
          end
        end
        SW_SWAP: begin
          src_q <= bsel_q;
          sw_q  <= SW_RUN;
        end
        default: sw_q <= SW_RUN;
      endcase
    end
  end

  // divide by two on selected source edges, held during switchover
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base_q <= 1'b0;
    end else if (stop_mode_in) begin
      base_q <= 1'b0;
    end else if (sw_q == SW_RUN && (src_q ? vco_rise : xtal_rise)) begin
      base_q <= ~base_q;
    end
  end
  assign base_clock_out = base_q;

  // outward clock, interrupt and loop controls, all registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crystal_clock_out  <= 1'b0;
      clockgen_interrupt <= 1'b0;
      loop_ctl_out       <= '0;
    end else begin
      crystal_clock_out  <= flt_q[3] & oscillator_enable_in
                            & ~stop_mode_in;
      clockgen_interrupt <= flag_q & ie_q & auto_q
                            & ~stop_mode_in;
      loop_ctl_out.osc_run   <= oscillator_enable_in;
      loop_ctl_out.loop_run  <= pon_q & oscillator_enable_in
                                & (vrs_q != 4'h0);
      loop_ctl_out.auto_bw   <= auto_q;
      loop_ctl_out.acq_track <= acq_man_q;
      loop_ctl_out.mul_n     <= eff_n(mul_q);
      loop_ctl_out.range_l   <= vrs_q;
    end
  end

  // read-back helper for checks
  logic rd_was_ctrl_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_was_ctrl_q <= 1'b0;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rd_was_ctrl_q <= rsel == 2'h1;
    end
  end

  a_irq_from_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    !stop_mode_in |=> clockgen_interrupt ==
      $past(flag_q & ie_q & auto_q))
    else $error("interrupt does not follow flag and enable");
  a_flag_on_tog: assert property (@(posedge aclk) disable iff (!aresetn)
    auto_q && lock_tog |=> flag_q)
    else $error("lock toggle did not set flag");
  a_flag_rd_clr: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_ctrl && !lock_tog |=> !flag_q)
    else $error("control read left flag set");
  a_ctrl_ones: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && rd_was_ctrl_q |-> s_axi_rdata[3:0] == 4'hf
      && (auto_q || s_axi_rdata[7:6] == 2'h0 || $changed(auto_q)))
    else $error("control low nibble not ones");
  a_bsel_needs_on: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(bsel_q) |-> $past(pon_q) && vrs_q != 4'h0)
    else $error("source select set while loop off");
  a_pon_held: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(bsel_q) && $past(pon_q) |-> pon_q)
    else $error("loop powered off with vco selected");
  a_mul_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
    pon_q |=> $stable(mul_q) && $stable(vrs_q))
    else $error("multiplier changed while loop on");
  a_vrs_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    vrs_q == 4'h0 |=> !bsel_q)
    else $error("select kept with zero range");
  a_base_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    sw_q != SW_RUN && !stop_mode_in ##1 !stop_mode_in
      |-> $stable(base_clock_out))
    else $error("base clock moved during switchover");
  a_loss_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    !bsel_q |=> !loss_q)
    else $error("loss bit set with crystal selected");
endmodule : cgc_top

// file: inc/cgc_consts.svh
// register map, field positions, reset values and timing counts
// Overview of operation
// - interrupt enable writable only in auto mode
// - lock toggle sets flag; flag and enable interrupt
// - flag reads zero in manual mode; reset clears
// - control register read clears flag; a lock toggle in the same cycle wins
// - loop power on at reset; locked while vco selected
// - vco select refused while loop is off
// - switchover waits three edges each, output held; the code skips the vco wait while the loop is stopped
// - base clock is selected source halved
// - reset and stop clear source select
// - control register low nibble reads ones
// - auto bandwidth bit writable, reset clears
// - settled indicator read-only in auto, else zero
// - tracking bit status in auto, saved manual value
// - tracking one, acquisition zero, reset clears
// - loss check: write one, wait n*4, read
// - loss detection only with vco selected
// - multiplier zero acts as one, reset six
// - multiplier and range frozen while loop on
// - range zero clears and blocks source select
// - range field resets to six
// - oscillator and loop run only when enabled
`ifndef CGC_CONSTS_SVH
`define CGC_CONSTS_SVH
`define CGC_OFS_CTRL    4'h0
`define CGC_OFS_PBW     4'h4
`define CGC_OFS_PMUL    4'h8
`define CGC_B_IE        7
`define CGC_B_FLAG      6
`define CGC_B_PON       5
`define CGC_B_BSEL      4
`define CGC_B_AUTO      7
`define CGC_B_SETTLE    6
`define CGC_B_TRACK     5
`define CGC_B_LOSS      4
`define CGC_RST_MUL     4'h6
`define CGC_RST_VRS     4'h6
`define CGC_SW_EDGES    2'h3
`define CGC_LOSS_SCALE  2
`endif

// file: inc/cgc_pkg.sv
// types shared by the clock generator control logic
package cgc_pkg;
  // base clock switchover sequence, gray from run to drain to swap; swap back to run flips both bits
  typedef enum logic [1:0] {
    SW_RUN   = 2'b00,
    SW_DRAIN = 2'b01,
    SW_SWAP  = 2'b11
  } cgc_sw_t;

  // status coming back from the analog loop
  typedef struct packed {
    logic locked;
    logic tracking;
  } cgc_stat_t;

  // controls going out to the analog loop
  typedef struct packed {
    logic       osc_run;
    logic       loop_run;
    logic       auto_bw;
    logic       acq_track;
    logic [3:0] mul_n;
    logic [3:0] range_l;
  } cgc_ctl_t;
endpackage : cgc_pkg

// file: testbench/cgc_loop_model.sv
// behavioural crystal, vco and lock detector facing the control block
module cgc_loop_model (
  input  wire logic              aclk,
  input  wire cgc_pkg::cgc_ctl_t ctl_in,
  input  wire logic              xtal_on,
  input  wire logic              lock_ok,
  output logic                   xtal_osc,
  output logic                   vco_out,
  output cgc_pkg::cgc_stat_t     stat_out
);
  import cgc_pkg::*;
  logic [3:0] xc = 4'h0;
  logic [1:0] vc = 2'h0;
  logic       xo = 1'b0;
  logic       vo = 1'b0;

  // one driver per pin, levels start low
  assign xtal_osc = xo;
  assign vco_out  = vo;

  // crystal: period of 16 bus cycles, stalls when told or disabled
  always @(posedge aclk) begin
    if (ctl_in.osc_run && xtal_on) begin
      xc <= xc + 4'h1;
      if (xc == 4'h7) begin
        xc       <= 4'h0;
        xo       <= ~xo;
      end
    end
  end

  // vco: period of 6 bus cycles, runs only while the loop is on
  always @(posedge aclk) begin
    if (ctl_in.loop_run) begin
      vc <= vc + 2'h1;
      if (vc == 2'h2) begin
        vc      <= 2'h0;
        vo      <= ~vo;
      end
    end
  end

  // lock and tracking follow the loop; the bench can knock lock out
  always_comb begin
    stat_out.locked   = ctl_in.loop_run & lock_ok;
    stat_out.tracking = ctl_in.loop_run & lock_ok;
  end
endmodule : cgc_loop_model

// file: testbench/test_pll_clock_gen_control.sv
// self-checking bench for the clock generator control block
`include "cgc_consts.svh"
module test_pll_clock_gen_control;
  timeunit 1ns;
  timeprecision 1ps;
  import cgc_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        stop_in = 1'b0, osc_en = 1'b1, xtal_on = 1'b1, lock_ok = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid, xtal, vco;
  logic        xclk_out, base_out, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  cgc_stat_t   stat;
  cgc_ctl_t    ctl;
  int          err_total = 0, n_tests = 0;
  logic [33:0] exp_q[$];
  logic [3:0]  n_v, l_v;

  // 50 mhz bus clock
  always #10 aclk = ~aclk;

  cgc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .xtal_osc_in(xtal), .vco_clock(vco),
    .loop_stat_in(stat), .oscillator_enable_in(osc_en),
    .stop_mode_in(stop_in), .loop_ctl_out(ctl),
    .crystal_clock_out(xclk_out), .base_clock_out(base_out),
    .clockgen_interrupt(irq));

  cgc_loop_model loop_m (.aclk(aclk), .ctl_in(ctl), .xtal_on(xtal_on),
    .lock_ok(lock_ok), .xtal_osc(xtal), .vco_out(vco), .stat_out(stat));

  task automatic chk(input string nm, input logic [33:0] e,
                     input logic [33:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  // axi write: address and data offered together, each dropped when taken
  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input logic [3:0] s = 4'h1, input logic [1:0] r = 2'h0);
    logic ah, wh;
    logic pa = 1'b1;
    logic pw = 1'b1;
    exp_q.push_back({r, 32'h0});
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      ah = pa && awready;
      wh = pw && wready;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      pa = pa && !ah;
      pw = pw && !wh;
    end
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr

  // axi read; the expected byte and response go to the queue
  task automatic rd(input logic [3:0] a, input logic [7:0] d,
                    input logic [1:0] r = 2'h0);
    exp_q.push_back({r, 24'h0, d});
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rd

  // base output must toggle once per rise of the selected source
  task automatic fq(input logic use_vco);
    int   ns = 0;
    int   nb = 0;
    logic ps, pb, s;
    ps = use_vco ? vco : xtal;
    pb = base_out;
    repeat (240) begin
      @(negedge aclk);
      s = use_vco ? vco : xtal;
      ns += int'(s && !ps);
      nb += int'(base_out !== pb);
      ps = s;
      pb = base_out;
    end
    chk("base_rate", 34'h0, (ns > nb + 1 || nb > ns + 1) ? 34'h1 : 34'h0);
  endtask : fq

  // responses checked half a cycle before their handshake edge
  always @(negedge aclk) begin
    if (bvalid && bready) chk("bresp", exp_q.pop_front(), {bresp, 32'h0});
    if (rvalid && rready) chk("rdata", exp_q.pop_front(), {rresp, rdata});
  end

  // watchdog: the whole sequence needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    stop_test();
  end

  // main sequence
  initial begin
    void'($urandom(32941));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`CGC_OFS_CTRL, 8'h2f);
    rd(`CGC_OFS_PBW, 8'h00);
    rd(`CGC_OFS_PMUL, 8'h66);
    rd(4'hc, 8'h00, 2'h2);
    wr(4'hc, 8'hff, 4'h1, 2'h2);
    wr(`CGC_OFS_CTRL, 8'h00, 4'h0);
    wr(`CGC_OFS_CTRL, 8'ha0);
    rd(`CGC_OFS_CTRL, 8'h2f);
    fq(1'b0);
    wr(`CGC_OFS_CTRL, 8'h00);
    wr(`CGC_OFS_CTRL, 8'h10);
    rd(`CGC_OFS_CTRL, 8'h0f);
    n_v = 4'($urandom_range(15, 0));
    l_v = 4'($urandom_range(15, 1));
    wr(`CGC_OFS_PMUL, {n_v, l_v});
    rd(`CGC_OFS_PMUL, {n_v, l_v});
    repeat (3) @(posedge aclk);
    chk("mul_n", (n_v == 4'h0) ? 34'h1 : {30'h0, n_v},
        {30'h0, ctl.mul_n});
    chk("range_l", {30'h0, l_v}, {30'h0, ctl.range_l});
    // loop on first, select in a second write, tracking left clear
    wr(`CGC_OFS_CTRL, 8'h20);
    wr(`CGC_OFS_CTRL, 8'h30);
    wr(`CGC_OFS_CTRL, 8'h10);
    rd(`CGC_OFS_CTRL, 8'h3f);
    wr(`CGC_OFS_PMUL, 8'h00);
    rd(`CGC_OFS_PMUL, {n_v, l_v});
    repeat (100) @(posedge aclk);
    fq(1'b1);
    // loss check: wait covers n times four vco rises for the largest n
    wr(`CGC_OFS_PBW, 8'h10);
    repeat (420) @(posedge aclk);
    rd(`CGC_OFS_PBW, 8'h00);
    // let a crystal edge already in the synchroniser drain first
    xtal_on <= 1'b0;
    repeat (8) @(posedge aclk);
    wr(`CGC_OFS_PBW, 8'h10);
    repeat (420) @(posedge aclk);
    rd(`CGC_OFS_PBW, 8'h10);
    // the loss result is sticky; a fresh check with crystal back clears it
    xtal_on <= 1'b1;
    repeat (20) @(posedge aclk);
    wr(`CGC_OFS_PBW, 8'h10);
    repeat (60) @(posedge aclk);
    rd(`CGC_OFS_PBW, 8'h00);
    wr(`CGC_OFS_PBW, 8'h80);
    repeat (20) @(posedge aclk);
    rd(`CGC_OFS_PBW, 8'he0);
    wr(`CGC_OFS_CTRL, 8'hb0);
    rd(`CGC_OFS_CTRL, 8'hbf);
    lock_ok <= 1'b0;
    repeat (12) @(posedge aclk);
    chk("irq_set", 34'h1, {33'h0, irq});
    rd(`CGC_OFS_CTRL, 8'hff);
    repeat (3) @(posedge aclk);
    chk("irq_clr", 34'h0, {33'h0, irq});
    rd(`CGC_OFS_CTRL, 8'hbf);
    rd(`CGC_OFS_PBW, 8'h80);
    lock_ok <= 1'b1;
    repeat (12) @(posedge aclk);
    // leave auto first: tracking is only writable once in manual
    wr(`CGC_OFS_PBW, 8'h00);
    wr(`CGC_OFS_PBW, 8'h20);
    rd(`CGC_OFS_PBW, 8'h20);
    rd(`CGC_OFS_CTRL, 8'h3f);
    chk("track", 34'h1, {33'h0, ctl.acq_track});
    chk("auto_bw", 34'h0, {33'h0, ctl.auto_bw});
    chk("irq_man", 34'h0, {33'h0, irq});
    wr(`CGC_OFS_PBW, 8'h00);
    stop_in <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("stop_out", 34'h0, {32'h0, xclk_out, base_out});
    stop_in <= 1'b0;
    repeat (10) @(posedge aclk);
    rd(`CGC_OFS_CTRL, 8'h2f);
    osc_en <= 1'b0;
    repeat (4) @(posedge aclk);
    chk("osc_off", 34'h0, {32'h0, ctl.osc_run, ctl.loop_run});
    osc_en <= 1'b1;
    repeat (10) @(posedge aclk);
    wr(`CGC_OFS_CTRL, 8'h00);
    wr(`CGC_OFS_PMUL, {n_v, 4'h0});
    rd(`CGC_OFS_PMUL, {n_v, 4'h0});
    wr(`CGC_OFS_CTRL, 8'h20);
    wr(`CGC_OFS_CTRL, 8'h30);
    rd(`CGC_OFS_CTRL, 8'h2f);
    stop_test();
  end
endmodule : test_pll_clock_gen_control
